/* hw/chb_pkg.sv */
// ============================================================
// card host bus controller constants
package chb_pkg;

  // pin roles of the card, fixed from reset to reset
  typedef enum logic [1:0] {
    CHB_MEM,
    CHB_IO,
    CHB_IDE
  } chb_mode_t;

  // ============================================================
  // widths
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned IDE_ADDR_W = 3;
  localparam int unsigned CNT_W      = 3;

  // ============================================================
  // task file data register, the only word-wide one
  localparam logic [2:0] IDE_DATA_REG = 3'h0;

  // ============================================================
  // cycle counts at 40 MHz (address setup, strobe low, hold)
  localparam logic [CNT_W-1:0] SETUP_CYC  = 3'h2;
  localparam logic [CNT_W-1:0] STROBE_CYC = 3'h4;
  localparam logic [CNT_W-1:0] HOLD_CYC   = 3'h1;

  // ============================================================
  // reset values of the card pins, and the lane enable codes
  localparam logic [ADDR_W-1:0] ADDR_RST  = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
  localparam logic [1:0]        LANE_NONE = 2'h0;
  localparam logic [1:0]        LANE_LOW  = 2'h1;
  localparam logic [1:0]        LANE_BOTH = 2'h3;

endpackage

/* hw/chb_host_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// Operation
// - host grounds every address line above the low three in task file mode.
// - task file registers are byte wide on low lane; data register is word wide.
// - even byte sits on lines 0 to 7, odd byte on lines 8 to 15; host puts a lone odd byte on lines 0 to 7.
// - card ignores cable select in card modes; host grounds it.
// - host keeps the DMA acknowledge high when not using DMA.
// - diagnostic and drive-active lines form the two-drive handshake.
// - host ties the memory write strobe high in task file mode.
module chb_host_ctrl
  import chb_pkg::*;
(
  input  wire logic                clk,          // 40 MHz clock
  input  wire logic                srst,         // sync reset, high
  input  wire chb_pkg::chb_mode_t  modeSel,      // mode taken during reset
  input  wire logic                reqValid,     // access request
  input  wire logic                reqWrite,     // 1 write, 0 read
  input  wire logic                reqAttr,      // attribute space, memory mode
  input  wire logic                reqWide,      // word access, card modes
  input  wire logic [chb_pkg::ADDR_W-1:0] reqAddr, // byte address
  input  wire logic [chb_pkg::DATA_W-1:0] reqWdata, // write data
  output logic                     busy,         // access in flight
  output logic                     done,         // one-cycle end pulse
  output logic [chb_pkg::DATA_W-1:0] rdata,      // read data
  output chb_pkg::chb_mode_t       modeNow,      // latched mode
  output logic                     battOk,       // both battery lines high
  output logic                     stsAlert,     // status-change level
  output logic                     stsChgPulse,  // status-change onset
  output logic                     audioLevel,   // audio line level
  output logic                     passDiag,     // diagnostic passed
  output logic                     diskActive,   // drive active / slave
  output logic [chb_pkg::ADDR_W-1:0] cardAddr,   // address pins
  input  wire logic [chb_pkg::DATA_W-1:0] cardDataIn, // data pins in
  output logic [chb_pkg::DATA_W-1:0] cardDataOut, // data pins out
  output logic [1:0]               cardDataOe,   // lane enables, bit1 upper
  output logic                     cardCe1N,     // enable 1 / select 0
  output logic                     cardCe2N,     // enable 2 / select 1
  output logic                     cardOeN,      // memory read strobe
  output logic                     cardWeN,      // memory write strobe
  output logic                     cardIordN,    // port read strobe
  output logic                     cardIowrN,    // port write strobe
  output logic                     cardRegN,     // attribute / dma ack
  output logic                     cardCselN,    // cable select
  output logic                     cardReset,    // card reset pin
  input  wire logic                cardBvd1,     // battery1/stschg/pdiag
  input  wire logic                cardBvd2      // battery2/audio/dasp
);
  import chb_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} chb_state_t;

  chb_state_t        state_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              write_q;
  logic              wide_q;
  logic              bvd1Prev_q;
  logic              strobeEnd;
  logic              ideWide;

  assign strobeEnd = (state_q == S_STROBE) && (cnt_q == '0);
  assign ideWide   = (reqAddr[IDE_ADDR_W-1:0] == IDE_DATA_REG);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ============================================================
  // mode latch, held until the next reset
  always_ff @(posedge clk) begin
    if (srst) begin
      modeNow <= modeSel;
    end
  end

  // ============================================================
  // access sequencer: setup, strobe, hold
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (reqValid) begin
            state_q <= S_SETUP;
            cnt_q   <= SETUP_CYC - 3'h1;
            busy    <= 1'b1;
          end
        end
        S_SETUP: begin
          if (cnt_q == '0) begin
            state_q <= S_STROBE;
            cnt_q   <= STROBE_CYC - 3'h1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        S_STROBE: begin
          if (cnt_q == '0) begin
            state_q <= S_HOLD;
            cnt_q   <= HOLD_CYC - 3'h1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        S_HOLD: begin
          if (cnt_q == '0) begin
            state_q <= S_IDLE;
            busy    <= 1'b0;
            done    <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // address, selects and write data, set up when a request is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      cardAddr    <= ADDR_RST;
      cardCe1N    <= 1'b1;
      cardCe2N    <= 1'b1;
      cardRegN    <= 1'b1;
      cardDataOut <= DATA_RST;
      write_q     <= 1'b0;
      wide_q      <= 1'b0;
    end else if (state_q == S_IDLE && reqValid) begin
      write_q  <= reqWrite;
      cardCe1N <= 1'b0;
      if (modeNow == CHB_IDE) begin
        // upper lines grounded; card would ignore them anyway
        cardAddr <= {{(ADDR_W-IDE_ADDR_W){1'b0}}, reqAddr[IDE_ADDR_W-1:0]};
        wide_q   <= ideWide;
        cardCe2N <= 1'b1;
        cardRegN <= 1'b1;
        cardDataOut <= ideWide ? reqWdata : {8'h00, reqWdata[7:0]};
      end else begin
        // word access starts on the even byte, so line 0 is cleared
        cardAddr <= reqWide ? {reqAddr[ADDR_W-1:1], 1'b0} : reqAddr;
        wide_q   <= reqWide;
        cardCe2N <= ~reqWide;
        cardRegN <= (modeNow == CHB_IO) ? 1'b0 : ~reqAttr;
        // a lone byte, even or odd, travels on the low lane for 8-bit hosts
        cardDataOut <= reqWide ? reqWdata : {8'h00, reqWdata[7:0]};
      end
    end else if (state_q == S_HOLD && cnt_q == '0) begin
      cardCe1N <= 1'b1;
      cardCe2N <= 1'b1;
      if (modeNow != CHB_IDE) begin
        cardRegN <= 1'b1;
      end
    end
  end

  // ============================================================
  // strobes and lane drive; read data caught at strobe release
  always_ff @(posedge clk) begin
    if (srst) begin
      cardOeN    <= 1'b1;
      cardWeN    <= 1'b1;
      cardIordN  <= 1'b1;
      cardIowrN  <= 1'b1;
      cardDataOe <= LANE_NONE;
      rdata      <= DATA_RST;
    end else if (state_q == S_SETUP && cnt_q == '0) begin
      // the memory write strobe stays high outside memory mode
      cardOeN   <= !(modeNow == CHB_MEM && !write_q);
      cardWeN   <= !(modeNow == CHB_MEM && write_q);
      cardIordN <= !(modeNow != CHB_MEM && !write_q);
      cardIowrN <= !(modeNow != CHB_MEM && write_q);
      if (write_q) begin
        cardDataOe <= wide_q ? LANE_BOTH : LANE_LOW;
      end
    end else if (strobeEnd) begin
      cardOeN   <= 1'b1;
      cardWeN   <= 1'b1;
      cardIordN <= 1'b1;
      cardIowrN <= 1'b1;
      if (!write_q) begin
        rdata <= wide_q ? cardDataIn : {8'h00, cardDataIn[7:0]};
      end
    end else if (state_q == S_HOLD && cnt_q == '0) begin
      cardDataOe <= LANE_NONE;
    end
  end

  // ============================================================
  // fixed pins: cable select grounded, card reset by mode polarity
  always_ff @(posedge clk) begin
    cardCselN <= 1'b0;
    if (srst) begin
      cardReset <= (modeSel != CHB_IDE);
    end else begin
      cardReset <= (modeNow == CHB_IDE);
    end
  end

  // ============================================================
  // status lines, read as their role in the latched mode
  always_ff @(posedge clk) begin
    if (srst) begin
      battOk      <= 1'b0;
      stsAlert    <= 1'b0;
      stsChgPulse <= 1'b0;
      audioLevel  <= 1'b0;
      passDiag    <= 1'b0;
      diskActive  <= 1'b0;
      bvd1Prev_q  <= 1'b1;
    end else begin
      bvd1Prev_q  <= cardBvd1;
      battOk      <= (modeNow == CHB_MEM) && cardBvd1 && cardBvd2;
      stsAlert    <= (modeNow == CHB_IO) && !cardBvd1;
      stsChgPulse <= (modeNow == CHB_IO) && !cardBvd1 && bvd1Prev_q;
      audioLevel  <= (modeNow == CHB_IO) && cardBvd2;
      passDiag    <= (modeNow == CHB_IDE) && !cardBvd1;
      diskActive  <= (modeNow == CHB_IDE) && !cardBvd2;
    end
  end

  // ============================================================
  // checks
  property p_ide_addr_low;
    (modeNow == CHB_IDE) && busy |-> cardAddr[ADDR_W-1:IDE_ADDR_W] == '0;
  endproperty
  a_ide_addr_low: assert property (p_ide_addr_low) else $error("upper address high");

  property p_ide_lanes;
    (modeNow == CHB_IDE) && $fell(cardIowrN) |->
      cardDataOe == ((cardAddr[2:0] == IDE_DATA_REG) ? LANE_BOTH : LANE_LOW);
  endproperty
  a_ide_lanes: assert property (p_ide_lanes) else $error("task file lane width wrong");

  property p_word_read;
    strobeEnd && !write_q && wide_q |=> rdata == $past(cardDataIn);
  endproperty
  a_word_read: assert property (p_word_read) else $error("byte lanes of read swapped");

  property p_io_reg;
    (modeNow == CHB_IO) && !cardIordN |-> !cardRegN && !cardCe1N;
  endproperty
  a_io_reg: assert property (p_io_reg) else $error("port cycle lacks select");

  property p_csel;
    (modeNow != CHB_IDE) |-> !cardCselN;
  endproperty
  a_csel: assert property (p_csel) else $error("cable select left high");

  property p_dmack_high;
    (modeNow == CHB_IDE) |-> cardRegN && cardWeN;
  endproperty
  a_dmack_high: assert property (p_dmack_high) else $error("ack or we low");

  property p_byte_upper;
    (state_q == S_STROBE) && !wide_q |-> !cardDataOe[1] && (cardCe2N || modeNow == CHB_IDE);
  endproperty
  a_byte_upper: assert property (p_byte_upper) else $error("upper lane on byte");

  property p_diag;
    (modeNow == CHB_IDE) |=> passDiag == !$past(cardBvd1);
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic level not followed");

  property p_mode_hold;
    1'b1 |=> $stable(modeNow);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed outside reset");

  property p_strobe_width;
    $fell(cardIordN) |-> !cardIordN [*4] ##1 cardIordN;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("read strobe width wrong");

endmodule

`default_nettype wire

/* tb/chb_card_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// card side: answers strobes, drives the status lines
module chb_card_model
  import chb_pkg::*;
(
  input  wire logic         clk,    // bench clock
  input  wire chb_mode_t    mode,   // mode the card was reset in
  input  wire logic [2:0]   evt,    // bit0 status change, bit1 diag, bit2 active
  input  wire logic [10:0]  addr,   // address pins
  input  wire logic [15:0]  dout,   // host data
  output logic [15:0]       din,    // card data
  input  wire logic         ce1N,   // enable 1
  input  wire logic         ce2N,   // enable 2
  input  wire logic         oeN,    // memory read strobe
  input  wire logic         weN,    // memory write strobe
  input  wire logic         iordN,  // port read strobe
  input  wire logic         iowrN,  // port write strobe
  output logic              bvd1,   // status line 1
  output logic              bvd2,   // status line 2
  output logic [15:0]       lastWr  // last word written
);
  import chb_pkg::*;
  logic [10:0] ea;
  logic [15:0] val;
  logic [15:0] holdQ = 16'h0000;
  logic        rd;
  logic        wide;
  // byte pattern is address based so every lane is distinct
  function automatic logic [7:0] pat(input logic [10:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  // task file mode sees the low three lines only; select and dma ack unused
  assign ea = (mode == CHB_IDE) ? {8'h00, addr[2:0]} : addr;
  assign wide = (mode == CHB_IDE) ? (ea == 11'h000) : !ce2N;
  assign rd = !ce1N && (!oeN || !iordN);
  // upper lane of a byte read keeps changing, never a stale copy
  assign val = wide ? {pat(ea | 11'h001), pat(ea & 11'h7fe)} : {~holdQ[15:8], pat(ea)};
  assign din = rd ? val : ~holdQ;
  always @(posedge clk) begin
    holdQ <= din;
    if (!ce1N && (!weN || !iowrN)) begin
      lastWr <= dout;
    end
  end
  // status lines follow the mode fixed at reset
  assign bvd1 = (mode == CHB_IO) ? !evt[0] :
                (mode == CHB_IDE) ? !evt[1] : 1'b1;
  assign bvd2 = (mode == CHB_IDE) ? !evt[2] : 1'b1;
endmodule
`default_nettype wire

/* tb/test_card_host_bus_signal_roles.sv */
`timescale 1ns/100ps
`default_nettype none
module test_card_host_bus_signal_roles;
  import chb_pkg::*;
  logic clk = 0, srst = 1, reqValid = 0, reqWrite = 0, reqAttr = 0, reqWide = 0;
  chb_mode_t modeSel = CHB_MEM, cardMode = CHB_MEM, modeNow;
  logic [2:0] evt = 3'h0;
  logic [10:0] reqAddr = 11'h000, cardAddr, sAddr;
  logic [15:0] reqWdata = 16'h0000, rdata, cardDataIn, cardDataOut, lastWr;
  logic [1:0] cardDataOe, sOe;
  logic busy, done, battOk, stsAlert, stsChgPulse, audioLevel, passDiag, diskActive;
  logic cardCe1N, cardCe2N, cardOeN, cardWeN, cardIordN, cardIowrN, cardRegN;
  logic cardCselN, cardReset, cardBvd1, cardBvd2, sRegN, sWeN, sCe2N;
  int mismatches = 0, comparisons = 0, cycles = 0;
  // ============================================================
  // clock, timeout and parts
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stop_test();
    end
  end
  chb_host_ctrl dut (.clk, .srst, .modeSel, .reqValid, .reqWrite, .reqAttr, .reqWide,
    .reqAddr, .reqWdata, .busy, .done, .rdata, .modeNow, .battOk, .stsAlert, .stsChgPulse,
    .audioLevel, .passDiag, .diskActive, .cardAddr, .cardDataIn, .cardDataOut, .cardDataOe,
    .cardCe1N, .cardCe2N, .cardOeN, .cardWeN, .cardIordN, .cardIowrN, .cardRegN, .cardCselN,
    .cardReset, .cardBvd1, .cardBvd2);
  chb_card_model card (.clk, .mode(cardMode), .evt, .addr(cardAddr), .dout(cardDataOut),
    .din(cardDataIn), .ce1N(cardCe1N), .ce2N(cardCe2N), .oeN(cardOeN), .weN(cardWeN),
    .iordN(cardIordN), .iowrN(cardIowrN), .bvd1(cardBvd1), .bvd2(cardBvd2), .lastWr);
  // ============================================================
  // shared tasks
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input chb_mode_t m);
    @(negedge clk);
    srst = 1;
    modeSel = m;
    cardMode = m;
    repeat (8) @(negedge clk);
    chk("csel", 16'h0000, cardCselN);
    chk("reset pin", (m == CHB_IDE) ? 16'h0000 : 16'h0001, cardReset);
    srst = 0;
    @(negedge clk);
    chk("mode", m, modeNow);
    chk("reset off", (m == CHB_IDE) ? 16'h0001 : 16'h0000, cardReset);
  endtask
  // one access; keeps the request up until busy shows it was taken
  task automatic acc(input logic w, input logic a, input logic wd1, input logic [10:0] ad,
                     input logic [15:0] wd);
    int n;
    n = 0;
    sWeN = 1;
    sOe = 2'h0;
    @(negedge clk);
    reqValid = 1;
    reqWrite = w;
    reqAttr = a;
    reqWide = wd1;
    reqAddr = ad;
    reqWdata = wd;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    reqValid = 0;
    while (done !== 1'b1 && n < 40) begin
      if (busy === 1'b1) begin
        sAddr = cardAddr;
        sRegN = cardRegN;
        sCe2N = cardCe2N;
        sWeN = sWeN & cardWeN;
        sOe = sOe | cardDataOe;
      end
      @(negedge clk);
      n++;
    end
    chk("done", 16'h0001, done);
  endtask
  // ============================================================
  // scenarios
  task automatic t_mem;
    do_reset(CHB_MEM);
    chk("batt", 16'h0001, battOk);
    acc(0, 0, 1, 11'h123, 16'h0000);
    chk("word rd", 16'h7978, rdata);
    chk("word addr", 16'h0122, sAddr);
    chk("word ce2", 16'h0000, sCe2N);
    acc(0, 1, 0, 11'h3ff, 16'h0000);
    chk("byte rd", 16'h00a5, rdata);
    chk("attr sel", 16'h0000, sRegN);
    chk("byte addr", 16'h03ff, sAddr);
    chk("byte ce2", 16'h0001, sCe2N);
    acc(1, 0, 1, 11'h040, 16'hbeef);
    chk("word wr", 16'hbeef, lastWr);
    chk("word lanes", 16'h0003, sOe);
    acc(1, 0, 0, 11'h041, 16'h00c3);
    chk("byte lanes", 16'h0001, sOe);
    chk("byte wr", 16'h00c3, lastWr[7:0]);
  endtask
  task automatic t_io;
    do_reset(CHB_IO);
    chk("audio", 16'h0001, audioLevel);
    chk("alert idle", 16'h0000, stsAlert);
    evt = 3'h1;
    @(negedge clk);
    chk("chg pulse", 16'h0001, stsChgPulse);
    @(negedge clk);
    chk("chg once", 16'h0000, stsChgPulse);
    chk("alert", 16'h0001, stsAlert);
    evt = 3'h0;
    acc(0, 0, 1, 11'h201, 16'h0000);
    chk("port rd", 16'h5b5a, rdata);
  endtask
  task automatic t_ide;
    do_reset(CHB_IDE);
    acc(0, 0, 0, 11'h7f8, 16'h0000);
    chk("high lines", 16'h0000, sAddr);
    chk("data reg", 16'h5b5a, rdata);
    chk("dma ack", 16'h0001, sRegN);
    chk("we tied", 16'h0001, sWeN);
    chk("cs1 idle", 16'h0001, sCe2N);
    acc(0, 0, 1, 11'h00d, 16'h0000);
    chk("reg addr", 16'h0005, sAddr);
    chk("reg rd", 16'h005f, rdata);
    acc(1, 0, 1, 11'h003, 16'h12a7);
    chk("reg lanes", 16'h0001, sOe);
    chk("reg wr", 16'h00a7, lastWr[7:0]);
    evt = 3'h6;
    repeat (2) @(negedge clk);
    chk("diag", 16'h0001, passDiag);
    chk("active", 16'h0001, diskActive);
    modeSel = CHB_MEM;
    repeat (3) @(negedge clk);
    chk("mode held", CHB_IDE, modeNow);
  endtask
  initial begin
    t_mem();
    t_io();
    t_ide();
    stop_test();
  end
endmodule
`default_nettype wire
